// ### hdl/gpib_consts.vh
`ifndef GPIB_CONSTS_VH
`define GPIB_CONSTS_VH

// ==========================================================
// Register byte offsets
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_TX 8'h08
`define A_RX 8'h0C
`define A_SRQ 8'h10

// ==========================================================
// Field positions, address limit and reset values
`define ST_CLR 8
`define ST_TRIG 9
`define RSV_BIT 6
`define EOI_BIT 8
`define ADDR_MAX 5'h1E
`define ADDR_RST 5'h01

// ==========================================================
// Bus answers
`define RESP_OK 2'h0
`define RESP_DEC 2'h3

// ==========================================================
// Interface commands, seven bits, parity ignored
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_GET 7'h08
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_UNL 7'h3F
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2

// ==========================================================
// Timing: data settle time before DAV, in ns
`define T1_NS 2000
`define CLK_NS 25

`endif

// ### hdl/gpib_remote_local_interface.v
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "gpib_consts.vh"

// What this block does
// - Primary address limited to 0 through 30
// - Full source handshake when talking
// - Full acceptor handshake when listening
// - Talker, serial poll, untalk on own listen
// - Listener, unlisten on own talk address
// - Service request and status byte on poll
// - Full remote/local with local lockout
// - No parallel poll answer at all
// - Device clear and group trigger handled
// - Never controller; addressed mode only
// - Remote enable moves local to remote
// - Remote ignores panel except output switch
// - Output switch returns local unless locked out
// - Mode changes keep all settings
// - Remote lamp lit only in remote
// - Local lockout disables switch return
// - Go-to-local as listener goes local
// - Clear discards input and output queue
// - Interface clear resets talker and listener
module gpib_remote_local_interface (
  input wire CLK, // 40 MHz clock
  input wire SYS_RST, // Async reset, high
  input wire [7:0] AWADDR, // Write address
  input wire AWVALID, // Write address valid
  output reg AWREADY, // Write address ready
  input wire [31:0] WDATA, // Write data
  input wire [3:0] WSTRB, // Byte enables
  input wire WVALID, // Write data valid
  output reg WREADY, // Write data ready
  output reg [1:0] BRESP, // Write answer
  output reg BVALID, // Write answer valid
  input wire BREADY, // Write answer ready
  input wire [7:0] ARADDR, // Read address
  input wire ARVALID, // Read address valid
  output reg ARREADY, // Read address ready
  output reg [31:0] RDATA, // Read data
  output reg [1:0] RRESP, // Read answer
  output reg RVALID, // Read data valid
  input wire RREADY, // Read data ready
  input wire [7:0] DIO_IN, // Data lines, pin level
  output reg [7:0] DIO_OUT, // Data drive level
  output reg DIO_OE_N, // Data drive enable, low
  input wire DAV_IN, // Data valid pin
  output reg DAV_OE_N, // Pull DAV low
  input wire NRFD_IN, // Not ready pin
  output reg NRFD_OE_N, // Pull NRFD low
  input wire NDAC_IN, // Not accepted pin
  output reg NDAC_OE_N, // Pull NDAC low
  input wire EOI_IN, // End pin
  output reg EOI_OE_N, // Pull EOI low
  output reg SRQ_OE_N, // Pull SRQ low
  input wire ATN_IN, // Attention pin
  input wire IFC_IN, // Interface clear pin
  input wire REN_IN, // Remote enable pin
  input wire OUT_SW_LOCAL, // Output switch at local
  output reg REMOTE_LED, // Remote lamp
  output reg PANEL_EN, // Dials and keys enabled
  output reg TRIG_PULSE, // Group trigger strobe
  output reg CLEAR_PULSE // Device clear strobe
);

  // ========================================================
  // States and timing
  localparam AH_RDY = 1'b0;
  localparam AH_GOT = 1'b1;
  localparam SH_IDLE = 2'd0;
  localparam SH_SET = 2'd1;
  localparam SH_ACC = 2'd2;
  localparam SH_END = 2'd3;
  // Least time, rounded up to whole cycles
  localparam integer SETTLE_FULL = (`T1_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [6:0] SETTLE = SETTLE_FULL[6:0];

  // Address compare against own primary address
  function hit;
    input [6:0] c;
    input [1:0] grp;
    input [4:0] a;
    begin
      hit = (c == {grp, a});
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `A_CTRL) || (a == `A_STAT) || (a == `A_TX) ||
               (a == `A_RX) || (a == `A_SRQ);
    end
  endfunction

  // ========================================================
  // Pin synchronisers
  reg [15:0] s1;
  reg [15:0] s2;
  reg ren_prev;
  reg sw_prev;
  wire [7:0] dio = ~s2[7:0];
  wire dav = ~s2[8];
  wire nrfd = ~s2[9];
  wire ndac = ~s2[10];
  wire eoi = ~s2[11];
  wire atn = ~s2[12];
  wire ifc = ~s2[13];
  wire ren = ~s2[14];
  wire sw_loc = s2[15];
  wire [6:0] cmd = dio[6:0];

  // Only the second stage is read by logic
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s1 <= 16'hFFFF;
      s2 <= 16'hFFFF;
    end else begin
      s1 <= {OUT_SW_LOCAL, REN_IN, IFC_IN, ATN_IN, EOI_IN, NDAC_IN, NRFD_IN, DAV_IN, DIO_IN};
      s2 <= s1;
    end
  end

  // ========================================================
  // Register bus slave
  reg [7:0] wa;
  reg [31:0] wd;
  reg [3:0] ws;
  reg wr_en;
  reg rd_rx;
  reg [31:0] rd_mux;
  wire do_wr = ~AWREADY & ~WREADY & ~BVALID;

  // Core state, declared here for the read mux
  reg [4:0] addr;
  reg remote;
  reg lockout;
  reg lacs;
  reg tacs;
  reg spms;
  reg [7:0] rx_data;
  reg rx_end;
  reg rx_valid;
  reg evt_clr;
  reg evt_trig;
  reg ah_st;
  reg dclr;
  reg [7:0] tx_data;
  reg tx_eoi;
  reg tx_valid;
  reg [7:0] stb;
  reg rsv;
  reg [1:0] sh_st;
  reg [6:0] cnt;

  always @* begin
    case (ARADDR)
      `A_CTRL: rd_mux = {27'h000_0000, addr};
      `A_STAT: rd_mux = {22'h00_0000, evt_trig, evt_clr, rsv, tx_valid,
                         rx_valid, spms, tacs, lacs, lockout, remote};
      `A_TX: rd_mux = {23'h00_0000, tx_eoi, tx_data};
      `A_RX: rd_mux = {23'h00_0000, rx_end, rx_data};
      `A_SRQ: rd_mux = {24'h00_0000, stb[7], rsv, stb[5:0]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Address and data may arrive in either order
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= `RESP_OK;
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RRESP <= `RESP_OK;
      RDATA <= 32'h0000_0000;
      wa <= 8'h00;
      wd <= 32'h0000_0000;
      ws <= 4'h0;
      wr_en <= 1'b0;
      rd_rx <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      rd_rx <= 1'b0;
      if (AWVALID && AWREADY) begin
        wa <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        wd <= WDATA;
        ws <= WSTRB;
        WREADY <= 1'b0;
      end
      if (do_wr) begin
        wr_en <= mapped(wa) & ws[0];
        BRESP <= mapped(wa) ? `RESP_OK : `RESP_DEC;
        BVALID <= 1'b1;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
      if (ARVALID && ARREADY) begin
        RDATA <= rd_mux;
        RRESP <= mapped(ARADDR) ? `RESP_OK : `RESP_DEC;
        rd_rx <= (ARADDR == `A_RX);
        RVALID <= 1'b1;
        ARREADY <= 1'b0;
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // ========================================================
  // Acceptor, addressing, commands, remote/local
  wire ah_act = atn | lacs;
  wire ah_ready = atn | ~rx_valid;

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr <= `ADDR_RST;
      remote <= 1'b0;
      lockout <= 1'b0;
      lacs <= 1'b0;
      tacs <= 1'b0;
      spms <= 1'b0;
      rx_data <= 8'h00;
      rx_end <= 1'b0;
      rx_valid <= 1'b0;
      evt_clr <= 1'b0;
      evt_trig <= 1'b0;
      ah_st <= AH_RDY;
      dclr <= 1'b0;
      ren_prev <= 1'b0;
      // Matches the synchroniser reset level, so no false edge
      sw_prev <= 1'b1;
      NRFD_OE_N <= 1'b1;
      NDAC_OE_N <= 1'b1;
      REMOTE_LED <= 1'b0;
      PANEL_EN <= 1'b1;
      TRIG_PULSE <= 1'b0;
      CLEAR_PULSE <= 1'b0;
    end else begin
      TRIG_PULSE <= 1'b0;
      CLEAR_PULSE <= 1'b0;
      dclr <= 1'b0;
      ren_prev <= ren;
      sw_prev <= sw_loc;
      if (wr_en && wa == `A_CTRL && wd[4:0] <= `ADDR_MAX) begin
        addr <= wd[4:0];
      end
      if (rd_rx) begin
        rx_valid <= 1'b0;
      end
      // Clears come first so a same-cycle event wins
      if (wr_en && wa == `A_STAT) begin
        if (wd[`ST_CLR]) evt_clr <= 1'b0;
        if (wd[`ST_TRIG]) evt_trig <= 1'b0;
      end
      if (!ren) begin
        remote <= 1'b0;
        lockout <= 1'b0;
      end else if (ren && !ren_prev && !remote) begin
        remote <= 1'b1;
      end else if (remote && sw_loc && !sw_prev && !lockout) begin
        remote <= 1'b0;
      end
      if (ifc) begin
        lacs <= 1'b0;
        tacs <= 1'b0;
        spms <= 1'b0;
        ah_st <= AH_RDY;
      end else begin
        case (ah_st)
          AH_RDY: begin
            if (ah_act && ah_ready && dav) begin
              ah_st <= AH_GOT;
              if (atn) begin
                if (hit(cmd, `GRP_LISTEN, addr)) begin
                  lacs <= 1'b1;
                  tacs <= 1'b0;
                end else if (cmd == `CMD_UNL) begin
                  lacs <= 1'b0;
                end
                if (hit(cmd, `GRP_TALK, addr)) begin
                  tacs <= 1'b1;
                  lacs <= 1'b0;
                end else if (cmd[6:5] == `GRP_TALK) begin
                  tacs <= 1'b0;
                end
                case (cmd)
                  `CMD_GTL: if (lacs) remote <= 1'b0;
                  `CMD_LLO: if (ren) lockout <= 1'b1;
                  `CMD_SDC, `CMD_DCL: begin
                    if (lacs || cmd == `CMD_DCL) begin
                      dclr <= 1'b1;
                      CLEAR_PULSE <= 1'b1;
                      rx_valid <= 1'b0;
                      evt_clr <= 1'b1;
                    end
                  end
                  `CMD_GET: begin
                    if (lacs) begin
                      TRIG_PULSE <= 1'b1;
                      evt_trig <= 1'b1;
                    end
                  end
                  `CMD_SPE: spms <= 1'b1;
                  `CMD_SPD: spms <= 1'b0;
                  default: spms <= spms;
                endcase
              end else begin
                rx_data <= dio;
                rx_end <= eoi;
                rx_valid <= 1'b1;
              end
            end
          end
          AH_GOT: begin
            if (!dav) ah_st <= AH_RDY;
          end
          default: ah_st <= AH_RDY;
        endcase
      end
      // Lines held only while taking part
      NRFD_OE_N <= ~(ah_act & ~ifc & ~(ah_st == AH_RDY & ah_ready));
      NDAC_OE_N <= ~(ah_act & ~ifc & (ah_st == AH_RDY));
      REMOTE_LED <= remote;
      PANEL_EN <= ~remote;
    end
  end

  // ========================================================
  // Source handshake and service request
  // talks only when addressed, never drives ATN
  wire sh_go = tacs & ~atn & ~ifc & (spms | tx_valid);
  wire sh_abort = ifc | atn | ~tacs;
  wire [7:0] poll_byte = {stb[7], rsv, stb[5:0]};

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_data <= 8'h00;
      tx_eoi <= 1'b0;
      tx_valid <= 1'b0;
      stb <= 8'h00;
      rsv <= 1'b0;
      sh_st <= SH_IDLE;
      cnt <= 7'h00;
      DIO_OUT <= 8'hFF;
      DIO_OE_N <= 1'b1;
      DAV_OE_N <= 1'b1;
      EOI_OE_N <= 1'b1;
      SRQ_OE_N <= 1'b1;
    end else begin
      case (sh_st)
        SH_IDLE: begin
          if (sh_go) begin
            DIO_OUT <= spms ? ~poll_byte : ~tx_data;
            EOI_OE_N <= ~(~spms & tx_eoi);
            cnt <= 7'h00;
            sh_st <= SH_SET;
          end
        end
        SH_SET: begin
          if (sh_abort) begin
            sh_st <= SH_IDLE;
          end else begin
            if (cnt != SETTLE) cnt <= cnt + 7'h01;
            if (cnt == SETTLE && !nrfd && ndac) sh_st <= SH_ACC;
          end
        end
        SH_ACC: begin
          if (sh_abort) begin
            sh_st <= SH_IDLE;
          end else if (!ndac) begin
            if (spms) rsv <= 1'b0;
            else tx_valid <= 1'b0;
            sh_st <= SH_END;
          end
        end
        SH_END: begin
          // Wait for acceptor to rearm before next byte
          if (sh_abort || ndac) sh_st <= SH_IDLE;
        end
        default: sh_st <= SH_IDLE;
      endcase
      if (dclr) tx_valid <= 1'b0;
      // Writes while busy are dropped, not queued
      if (wr_en && wa == `A_TX && !tx_valid) begin
        tx_data <= wd[7:0];
        tx_eoi <= wd[`EOI_BIT] & ws[1];
        tx_valid <= 1'b1;
      end
      if (wr_en && wa == `A_SRQ) begin
        stb <= wd[7:0];
        rsv <= wd[`RSV_BIT];
      end
      DIO_OE_N <= ~((sh_st == SH_SET) | (sh_st == SH_ACC)) | sh_abort;
      DAV_OE_N <= ~(sh_st == SH_ACC) | sh_abort;
      // EOI stands with the byte and drops together with DAV
      if ((sh_st == SH_IDLE && !sh_go) || sh_st == SH_END || sh_abort) EOI_OE_N <= 1'b1;
      SRQ_OE_N <= ~rsv;
    end
  end

endmodule

// ### tb/gpib_props.sv
`timescale 1ns/10ps
// ==========================================
// Pin-level checks beside the port block
module gpib_props (
  input wire CLK, // Clock
  input wire SYS_RST, // Reset
  input wire AWVALID, // AW valid
  input wire AWREADY, // AW ready
  input wire WVALID, // W valid
  input wire WREADY, // W ready
  input wire BVALID, // B valid
  input wire ARVALID, // AR valid
  input wire ARREADY, // AR ready
  input wire RVALID, // R valid
  input wire REMOTE_LED, // Lamp
  input wire PANEL_EN, // Panel on
  input wire TRIG_PULSE, // Trigger
  input wire CLEAR_PULSE, // Clear
  input wire DIO_OE_N, // Data drive
  input wire DAV_OE_N, // DAV drive
  input wire ATN_IN, // Attention
  input wire IFC_IN, // Interface clear
  input wire REN_IN // Remote enable
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // Lamp and panel are always opposite
  chk_lamp_panel: assert property (REMOTE_LED != PANEL_EN)
    else $error("lamp and panel agree");
  chk_b_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("write answer late");
  chk_r_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  chk_b_ready: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("ready during answer");
  chk_trig_pulse: assert property (TRIG_PULSE |=> !TRIG_PULSE)
    else $error("trigger too long");
  chk_clear_pulse: assert property (CLEAR_PULSE |=> !CLEAR_PULSE)
    else $error("clear too long");
  chk_dav_data: assert property (!DAV_OE_N |-> !DIO_OE_N)
    else $error("DAV without data");
  // Sync delay plus one cycle allowed before release
  chk_atn_quiet: assert property (!ATN_IN [*5] |-> DAV_OE_N && DIO_OE_N)
    else $error("driving under attention");
  chk_ifc_quiet: assert property (!IFC_IN [*5] |-> DIO_OE_N)
    else $error("driving under clear");
  chk_ren_local: assert property (REN_IN [*6] |-> !REMOTE_LED)
    else $error("remote without enable");
  cover property ($rose(REMOTE_LED));
  cover property (!DAV_OE_N);
  cover property (TRIG_PULSE);
endmodule

// ### tb/gpib_ctl_model.sv
`timescale 1ns/10ps
// ==========================================
// Bus controller on the far side
module gpib_ctl_model (
  input wire CLK, // Clock
  input wire dav, // DAV level
  input wire nrfd, // NRFD level
  input wire ndac, // NDAC level
  input wire [7:0] dio, // Data levels
  output logic c_atn, // ATN drive
  output logic c_dav, // DAV drive
  output logic c_nrfd, // NRFD drive
  output logic c_ndac, // NDAC drive
  output logic [7:0] c_dio // Data drive
);
  int dly = 0; // Extra acceptor delay
  // All lines start released
  initial begin
    c_atn = 1'h1;
    c_dav = 1'h1;
    c_nrfd = 1'h1;
    c_ndac = 1'h1;
    c_dio = 8'hFF;
  end
  task automatic send(input [7:0] b, input a);
    c_atn <= !a;
    repeat (4) @(posedge CLK);
    c_nrfd <= 1'h1;
    c_ndac <= 1'h1;
    do @(posedge CLK); while (!(nrfd && !ndac));
    c_dio <= ~b;
    repeat (4) @(posedge CLK);
    c_dav <= 1'h0;
    do @(posedge CLK); while (!ndac);
    // Released lines go to the pull-up level
    c_dav <= 1'h1;
    c_dio <= 8'hFF;
    repeat (6) @(posedge CLK);
  endtask
  // Listener side; dly makes a slow acceptor
  task automatic rcv(output [7:0] b);
    c_atn <= 1'h1;
    c_ndac <= 1'h0;
    c_nrfd <= 1'h1;
    do @(posedge CLK); while (dav);
    b = ~dio;
    c_nrfd <= 1'h0;
    repeat (dly) @(posedge CLK);
    c_ndac <= 1'h1;
    do @(posedge CLK); while (!dav);
    c_ndac <= 1'h0;
    @(posedge CLK);
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
`include "gpib_consts.vh"
// ==========================================
// Bench top
module tb_top;
  logic CLK = 1'h0;
  logic SYS_RST = 1'h1;
  logic [7:0] AWADDR = 8'h00;
  logic [7:0] ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [3:0] WSTRB = 4'hF;
  logic AWVALID = 1'h0;
  logic WVALID = 1'h0;
  logic BREADY = 1'h0;
  logic ARVALID = 1'h0;
  logic RREADY = 1'h0;
  logic OUT_SW_LOCAL = 1'h0;
  logic ren_n = 1'h1;
  logic ifc_n = 1'h1;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, DIO_OE_N, DAV_OE_N, NRFD_OE_N, NDAC_OE_N;
  wire EOI_OE_N, SRQ_OE_N, REMOTE_LED, PANEL_EN, TRIG_PULSE, CLEAR_PULSE, c_atn, c_dav, c_nrfd, c_ndac;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [7:0] DIO_OUT, c_dio;
  // Open-collector lines: any low driver wins
  wire [7:0] dio = c_dio & (DIO_OE_N ? 8'hFF : DIO_OUT);
  wire dav = c_dav & DAV_OE_N;
  wire nrfd = c_nrfd & NRFD_OE_N;
  wire ndac = c_ndac & NDAC_OE_N;
  int bad_count = 0;
  int comparisons = 0;
  int ntrig = 0;
  int nclr = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [7:0] b;
  logic eoi_seen = 1'h0;
  // Command rows beside expected status bits
  logic [7:0] cmd [11] = '{8'h14, 8'h25, 8'h11, 8'h08, 8'h04, 8'h45, 8'h18, 8'h19, 8'h25, 8'h01, 8'h3F};
  logic [9:0] est [11] = '{10'h101, 10'h005, 10'h007, 10'h207, 10'h107, 10'h00B, 10'h01B, 10'h00B,
                           10'h007, 10'h006, 10'h002};
  gpib_remote_local_interface i_dut (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .AWADDR(AWADDR),
    .AWVALID(AWVALID),
    .AWREADY(AWREADY),
    .WDATA(WDATA),
    .WSTRB(WSTRB),
    .WVALID(WVALID),
    .WREADY(WREADY),
    .BRESP(BRESP),
    .BVALID(BVALID),
    .BREADY(BREADY),
    .ARADDR(ARADDR),
    .ARVALID(ARVALID),
    .ARREADY(ARREADY),
    .RDATA(RDATA),
    .RRESP(RRESP),
    .RVALID(RVALID),
    .RREADY(RREADY),
    .DIO_IN(dio),
    .DIO_OUT(DIO_OUT),
    .DIO_OE_N(DIO_OE_N),
    .DAV_IN(dav),
    .DAV_OE_N(DAV_OE_N),
    .NRFD_IN(nrfd),
    .NRFD_OE_N(NRFD_OE_N),
    .NDAC_IN(ndac),
    .NDAC_OE_N(NDAC_OE_N),
    .EOI_IN(EOI_OE_N),
    .EOI_OE_N(EOI_OE_N),
    .SRQ_OE_N(SRQ_OE_N),
    .ATN_IN(c_atn),
    .IFC_IN(ifc_n),
    .REN_IN(ren_n),
    .OUT_SW_LOCAL(OUT_SW_LOCAL),
    .REMOTE_LED(REMOTE_LED),
    .PANEL_EN(PANEL_EN),
    .TRIG_PULSE(TRIG_PULSE),
    .CLEAR_PULSE(CLEAR_PULSE)
  );
  gpib_ctl_model i_ctl (
    .CLK(CLK),
    .dav(dav),
    .nrfd(nrfd),
    .ndac(ndac),
    .dio(dio),
    .c_atn(c_atn),
    .c_dav(c_dav),
    .c_nrfd(c_nrfd),
    .c_ndac(c_ndac),
    .c_dio(c_dio)
  );
  always #12.5 CLK = ~CLK;
  // Pulse counters
  always @(posedge CLK) begin
    ntrig <= ntrig + TRIG_PULSE;
    nclr <= nclr + CLEAR_PULSE;
  end
  // EOI level while DAV is held low
  always @(posedge CLK) begin
    if (!dav) eoi_seen <= !EOI_OE_N;
  end
  task automatic cmp(input [31:0] s, input [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
    end while (BVALID !== 1'h1);
    rs = BRESP;
    BREADY <= 1'h0;
  endtask
  task automatic rdr(input [7:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'h0;
    end while (RVALID !== 1'h1);
    rd = RDATA;
    rs = RRESP;
    RREADY <= 1'h0;
  endtask
  // Switch and remote enable, then let syncs settle
  task automatic pin(input s, input r);
    OUT_SW_LOCAL <= s;
    ren_n <= r;
    repeat (6) @(posedge CLK);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'h0;
    cmp(PANEL_EN, 1);
    rdr(`A_CTRL);
    cmp(rd, `ADDR_RST);
    wr(`A_CTRL, 31);
    rdr(`A_CTRL);
    cmp(rd, `ADDR_RST);
    wr(`A_CTRL, `ADDR_MAX);
    rdr(`A_CTRL);
    cmp(rd, 30);
    wr(8'h14, 5);
    cmp(rs, `RESP_DEC);
    rdr(8'h14);
    cmp(rd, 0);
    cmp(rs, `RESP_DEC);
    wr(`A_CTRL, 5);
    $display("test registers done");
    pin(0, 0);
    cmp(REMOTE_LED, 1);
    cmp(PANEL_EN, 0);
    pin(1, 0);
    cmp(REMOTE_LED, 0);
    pin(0, 1);
    pin(0, 0);
    cmp(REMOTE_LED, 1);
    $display("test remote done");
    for (int i = 0; i < 11; i++) begin
      i_ctl.send(cmd[i], 1'h1);
      rdr(`A_STAT);
      cmp(rd[9:0], est[i]);
      wr(`A_STAT, 32'h0000_0300);
    end
    cmp(ntrig + 8 * nclr, 17);
    $display("test commands done");
    pin(0, 1);
    pin(0, 0);
    i_ctl.send(8'h11, 1'h1);
    pin(1, 0);
    cmp(REMOTE_LED, 1);
    rdr(`A_CTRL);
    cmp(rd, 5);
    pin(0, 0);
    $display("test lockout done");
    i_ctl.send(8'h25, 1'h1);
    i_ctl.send(8'hA5, 1'h0);
    rdr(`A_RX);
    cmp(rd, 32'h0000_00A5);
    i_ctl.send(8'h45, 1'h1);
    wr(`A_TX, 32'h0000_013C);
    i_ctl.dly = 5;
    i_ctl.rcv(b);
    cmp(b, 8'h3C);
    cmp(eoi_seen, 1);
    wr(`A_SRQ, 32'h0000_0040);
    repeat (3) @(posedge CLK);
    cmp(SRQ_OE_N, 0);
    i_ctl.send(8'h18, 1'h1);
    i_ctl.rcv(b);
    cmp(b, 8'h40);
    cmp(eoi_seen, 0);
    repeat (4) @(posedge CLK);
    cmp(SRQ_OE_N, 1);
    i_ctl.send(8'h19, 1'h1);
    // Queued byte under attention, then emptied by clear
    wr(`A_TX, 32'h0000_0055);
    rdr(`A_STAT);
    cmp(rd[6], 1);
    i_ctl.send(8'h14, 1'h1);
    rdr(`A_STAT);
    cmp(rd[6], 0);
    $display("test transfer done");
    ifc_n <= 1'h0;
    repeat (6) @(posedge CLK);
    ifc_n <= 1'h1;
    rdr(`A_STAT);
    cmp(rd[3:2], 0);
    $display("test clear done");
    summarize;
  end
  // Watchdog against a hung handshake
  initial begin
    #500us;
    bad_count++;
    summarize;
  end
endmodule
bind gpib_remote_local_interface gpib_props i_chk (
  .CLK(CLK),
  .SYS_RST(SYS_RST),
  .AWVALID(AWVALID),
  .AWREADY(AWREADY),
  .WVALID(WVALID),
  .WREADY(WREADY),
  .BVALID(BVALID),
  .ARVALID(ARVALID),
  .ARREADY(ARREADY),
  .RVALID(RVALID),
  .REMOTE_LED(REMOTE_LED),
  .PANEL_EN(PANEL_EN),
  .TRIG_PULSE(TRIG_PULSE),
  .CLEAR_PULSE(CLEAR_PULSE),
  .DIO_OE_N(DIO_OE_N),
  .DAV_OE_N(DAV_OE_N),
  .ATN_IN(ATN_IN),
  .IFC_IN(IFC_IN),
  .REN_IN(REN_IN)
);
